// ### hw/pif_pkg.sv
/*
  Package for the peripheral interrupt flag block: register offsets, bit
  positions, reset values and capture/compare modes.
  Assumes a 32-bit APB slave; the offsets here are word indices and the
  bus address of a register is four times its index.
*/
package pif_pkg;

  // ------------------------------------------------------------
  // Register offsets (word indices)
  // ------------------------------------------------------------
  localparam logic [11:0] PIF_FLAGS_ONE_OFF   = 12'h00c;
  localparam logic [11:0] PIF_FLAGS_TWO_OFF   = 12'h00d;
  localparam logic [11:0] PIF_ENABLES_ONE_OFF = 12'h08c;
  localparam logic [11:0] PIF_ENABLES_TWO_OFF = 12'h08d;
  localparam logic [11:0] PIF_CORE_CTRL_OFF   = 12'h00b;

  // ------------------------------------------------------------
  // Bit positions
  // ------------------------------------------------------------
  localparam int PIF_BIT_CONV   = 6;
  localparam int PIF_BIT_SERIAL = 3;
  localparam int PIF_BIT_CAPCMP = 2;
  localparam int PIF_BIT_PERIOD = 1;
  localparam int PIF_BIT_WIDE   = 0;
  localparam int PIF_BIT_LVD    = 7;
  localparam int PIF_BIT_BUSCOL = 3;
  localparam int PIF_BIT_GLOBAL = 7;
  localparam int PIF_BIT_GATE   = 6;

  localparam logic [7:0] PIF_ONE_MASK  = 8'h4f;
  localparam logic [7:0] PIF_TWO_MASK  = 8'h88;
  localparam logic [7:0] PIF_CORE_MASK = 8'hc0;
  localparam logic [7:0] PIF_RESET_VAL = 8'h00;

  // ------------------------------------------------------------
  // Capture/compare unit modes
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PIF_CC_OFF     = 2'b00,
    PIF_CC_CAPTURE = 2'b01,
    PIF_CC_COMPARE = 2'b11,
    PIF_CC_PWM     = 2'b10
  } pif_cc_mode_t;

endpackage

// ### hw/pif_reg_if.sv
/*
  Interface carrying one register write/read port between the top and the
  flag bank. Assumes a single clock domain.
*/
`timescale 1ns/1ns
interface pif_reg_if;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] set;
  logic [7:0] value;

  modport owner (input wr, input wdata, input set, output value);
  modport user  (output wr, output wdata, output set, input value);
endinterface

// ### hw/pif_flag_bank.sv
/*
  One 8-bit register of flags or enables: software writes, hardware sets.
  Assumes the write strobe is a single-cycle pulse on pclk.
*/
`timescale 1ns/1ns
module pif_flag_bank
  import pif_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register port
  pif_reg_if.owner rp
);

  logic [7:0] bits;

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bits <= PIF_RESET_VAL;
    else if (rp.wr)
      bits <= (rp.wdata | rp.set) & MASK;
    else
      bits <= (bits | rp.set) & MASK;
  end

  assign rp.value = bits;

endmodule

// ### hw/pif_top.sv
/*
  Peripheral interrupt enable and flag registers with an APB slave.
  Assumes peripherals deliver one-cycle event pulses synchronous to pclk,
  and that each register sits at a byte address four times its word index.
*/
// Chosen here: the APB interface to the registers.
//
// Notes on behaviour
// - Enable register one at 0x8c: bits 6,3,2,1,0 enable the five sources.
// - Flag register one at 0x0c, bits match the enable positions.
// - Bits 7,5,4 of both registers read zero and ignore writes.
// - All implemented bits reset to zero and are software read/write.
// - Flags set on their event whatever the enable or global bits.
// - Converter flag bit 6 sets when a conversion completes.
// - Serial flag bit 3 sets when a transfer finishes, any mode.
// - Master mode: start, stop, restart or acknowledge done sets serial flag.
// - Master mode: start or stop seen while idle sets serial flag.
// - Hardware never clears the serial flag; software must.
// - Capture mode: a timer capture sets capture/compare flag bit 2.
// - Compare mode: a timer match sets the capture/compare flag.
// - Period timer equal to period register sets flag bit 1.
// - Wide timer overflow sets flag bit 0.
// - Enable register two at 0x8d holds collision and low-voltage enables.
// - Flag register two holds collision and low-voltage flags, set regardless.
// - No peripheral request reaches the core without the gate bit set.
`timescale 1ns/1ns
module pif_top
  import pif_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral events as one-cycle pulses, plus mode and idle levels
  input  wire logic        conv_done,
  input  wire logic        serial_xfer_done,
  input  wire logic        serial_master_mode,
  input  wire logic        serial_seq_done,
  input  wire logic        serial_idle,
  input  wire logic        bus_cond_seen,
  input  wire logic [1:0]  capcmp_mode,
  input  wire logic        capture_event,
  input  wire logic        compare_match,
  input  wire logic        period_match,
  input  wire logic        wide_timer_ovf,
  input  wire logic        bus_collision,
  input  wire logic        low_voltage,
  // Core
  output logic             periph_irq,
  output logic             core_irq
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic       access;
  logic       wr_en;
  logic       hit;
  logic [7:0] rd_val;
  logic [7:0] core_ctrl;

  assign access  = psel && penable;
  assign wr_en   = access && pwrite;
  assign pready  = 1'b1;

  // Index 0x8d is not word aligned, so every index is scaled to a byte address
  function automatic logic is_at(input logic [11:0] a, input logic [11:0] idx);
    return a == {idx[9:0], 2'b00};
  endfunction

  pif_reg_if f1_p ();
  pif_reg_if f2_p ();
  pif_reg_if e1_p ();
  pif_reg_if e2_p ();

  assign f1_p.wr    = wr_en && is_at(paddr, PIF_FLAGS_ONE_OFF);
  assign f2_p.wr    = wr_en && is_at(paddr, PIF_FLAGS_TWO_OFF);
  assign e1_p.wr    = wr_en && is_at(paddr, PIF_ENABLES_ONE_OFF);
  assign e2_p.wr    = wr_en && is_at(paddr, PIF_ENABLES_TWO_OFF);
  assign f1_p.wdata = pwdata[7:0];
  assign f2_p.wdata = pwdata[7:0];
  assign e1_p.wdata = pwdata[7:0];
  assign e2_p.wdata = pwdata[7:0];
  assign e1_p.set   = 8'h00;
  assign e2_p.set   = 8'h00;

  // ------------------------------------------------------------
  // Flag set sources
  // ------------------------------------------------------------
  logic serial_set;
  logic capcmp_set;

  // Serial flag is only ever set here; no hardware clear path exists
  assign serial_set = serial_xfer_done
                    | (serial_master_mode & serial_seq_done)
                    | (serial_master_mode & serial_idle & bus_cond_seen);

  // PWM and off modes never set it
  always_comb
  begin
    capcmp_set = 1'b0;
    case (capcmp_mode)
      PIF_CC_CAPTURE: capcmp_set = capture_event;
      PIF_CC_COMPARE: capcmp_set = compare_match;
      default:        capcmp_set = 1'b0;
    endcase
  end

  always_comb
  begin
    f1_p.set                 = 8'h00;
    f1_p.set[PIF_BIT_CONV]   = conv_done;
    f1_p.set[PIF_BIT_SERIAL] = serial_set;
    f1_p.set[PIF_BIT_CAPCMP] = capcmp_set;
    f1_p.set[PIF_BIT_PERIOD] = period_match;
    f1_p.set[PIF_BIT_WIDE]   = wide_timer_ovf;
    f2_p.set                 = 8'h00;
    f2_p.set[PIF_BIT_BUSCOL] = bus_collision;
    f2_p.set[PIF_BIT_LVD]    = low_voltage;
  end

  pif_flag_bank
  #(
    .MASK    (PIF_ONE_MASK)
  )
  u_flags_one
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rp      (f1_p)
  );

  pif_flag_bank
  #(
    .MASK    (PIF_TWO_MASK)
  )
  u_flags_two
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rp      (f2_p)
  );

  pif_flag_bank
  #(
    .MASK    (PIF_ONE_MASK)
  )
  u_enables_one
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rp      (e1_p)
  );

  pif_flag_bank
  #(
    .MASK    (PIF_TWO_MASK)
  )
  u_enables_two
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rp      (e2_p)
  );

  // ------------------------------------------------------------
  // Core gate bits (global enable and peripheral gate)
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_ctrl <= PIF_RESET_VAL;
    else if (wr_en && is_at(paddr, PIF_CORE_CTRL_OFF))
      core_ctrl <= pwdata[7:0] & PIF_CORE_MASK;
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 8'h00;
    if (is_at(paddr, PIF_FLAGS_ONE_OFF))
      rd_val = f1_p.value;
    else if (is_at(paddr, PIF_FLAGS_TWO_OFF))
      rd_val = f2_p.value;
    else if (is_at(paddr, PIF_ENABLES_ONE_OFF))
      rd_val = e1_p.value;
    else if (is_at(paddr, PIF_ENABLES_TWO_OFF))
      rd_val = e2_p.value;
    else if (is_at(paddr, PIF_CORE_CTRL_OFF))
      rd_val = core_ctrl;
    else
      hit = 1'b0;
  end

  assign prdata  = {24'h000000, rd_val};
  assign pslverr = access && !hit;

  // ------------------------------------------------------------
  // Requests to the core
  // ------------------------------------------------------------
  logic any_pending;
  assign any_pending = |((f1_p.value & e1_p.value) | (f2_p.value & e2_p.value));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_irq <= 1'b0;
    else
      periph_irq <= any_pending & core_ctrl[PIF_BIT_GATE];
  end

  // Global enable only gates what the peripheral gate already lets through
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_irq <= 1'b0;
    else
      core_irq <= any_pending & core_ctrl[PIF_BIT_GATE] & core_ctrl[PIF_BIT_GLOBAL];
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  conv_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> f1_p.value[PIF_BIT_CONV]) else $error("converter flag not set");
  serial_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    serial_xfer_done |=> f1_p.value[PIF_BIT_SERIAL]) else $error("serial flag not set");
  serial_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    f1_p.value[PIF_BIT_SERIAL] && !f1_p.wr |=> f1_p.value[PIF_BIT_SERIAL]) else $error("serial flag self-cleared");
  pwm_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    capcmp_mode == PIF_CC_PWM && !f1_p.wr && !f1_p.value[PIF_BIT_CAPCMP] |=> !f1_p.value[PIF_BIT_CAPCMP])
    else $error("capcmp flag set in pwm");
  period_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_match |=> f1_p.value[PIF_BIT_PERIOD]) else $error("period flag not set");
  wide_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wide_timer_ovf |=> f1_p.value[PIF_BIT_WIDE]) else $error("overflow flag not set");
  unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (f1_p.value & ~PIF_ONE_MASK) == 8'h00 && (e1_p.value & ~PIF_ONE_MASK) == 8'h00)
    else $error("unimplemented bit set");
  gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !core_ctrl[PIF_BIT_GATE] |=> !periph_irq) else $error("request without gate");
  req_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_pending && core_ctrl[PIF_BIT_GATE] |=> periph_irq) else $error("request missing");
  bus_col_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_collision |=> f2_p.value[PIF_BIT_BUSCOL]) else $error("collision flag not set");
  low_volt_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_voltage |=> f2_p.value[PIF_BIT_LVD]) else $error("low-voltage flag not set");
  seq_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    serial_master_mode && serial_seq_done |=> f1_p.value[PIF_BIT_SERIAL]) else $error("sequence flag not set");
  idle_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    serial_master_mode && serial_idle && bus_cond_seen |=> f1_p.value[PIF_BIT_SERIAL])
    else $error("idle condition flag not set");
  capture_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    capcmp_mode == PIF_CC_CAPTURE && capture_event |=> f1_p.value[PIF_BIT_CAPCMP])
    else $error("capture flag not set");
  compare_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    capcmp_mode == PIF_CC_COMPARE && compare_match |=> f1_p.value[PIF_BIT_CAPCMP])
    else $error("compare flag not set");
  conv_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !conv_done && !f1_p.wr && !f1_p.value[PIF_BIT_CONV] |=> !f1_p.value[PIF_BIT_CONV])
    else $error("converter flag set without event");
  serial_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_xfer_done && !serial_seq_done && !bus_cond_seen && !f1_p.wr && !f1_p.value[PIF_BIT_SERIAL]
    |=> !f1_p.value[PIF_BIT_SERIAL]) else $error("serial flag set without event");
  period_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !period_match && !f1_p.wr && !f1_p.value[PIF_BIT_PERIOD] |=> !f1_p.value[PIF_BIT_PERIOD])
    else $error("period flag set without event");
  wide_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wide_timer_ovf && !f1_p.wr && !f1_p.value[PIF_BIT_WIDE] |=> !f1_p.value[PIF_BIT_WIDE])
    else $error("overflow flag set without event");
  conv_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    f1_p.value[PIF_BIT_CONV] && !f1_p.wr |=> f1_p.value[PIF_BIT_CONV])
    else $error("converter flag self-cleared");
  capcmp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    f1_p.value[PIF_BIT_CAPCMP] && !f1_p.wr |=> f1_p.value[PIF_BIT_CAPCMP])
    else $error("capcmp flag self-cleared");
  period_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    f1_p.value[PIF_BIT_PERIOD] && !f1_p.wr |=> f1_p.value[PIF_BIT_PERIOD])
    else $error("period flag self-cleared");
  wide_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    f1_p.value[PIF_BIT_WIDE] && !f1_p.wr |=> f1_p.value[PIF_BIT_WIDE])
    else $error("overflow flag self-cleared");
  two_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !f2_p.wr |=> (f2_p.value & $past(f2_p.value)) == $past(f2_p.value))
    else $error("register two flag self-cleared");
  unimpl_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (f2_p.value & ~PIF_TWO_MASK) == 8'h00 && (e2_p.value & ~PIF_TWO_MASK) == 8'h00)
    else $error("unused register two bit set");

  // ------------------------------------------------------------
  // Checks: register bus
  // ------------------------------------------------------------
  en_one_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    e1_p.wr |=> e1_p.value == ($past(pwdata[7:0]) & PIF_ONE_MASK))
    else $error("enable one write lost");
  en_one_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !e1_p.wr |=> $stable(e1_p.value)) else $error("enable one changed without write");
  flags_one_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    f1_p.wr && f1_p.set == 8'h00 |=> f1_p.value == ($past(pwdata[7:0]) & PIF_ONE_MASK))
    else $error("flag one write lost");
  en_two_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    e2_p.wr |=> e2_p.value == ($past(pwdata[7:0]) & PIF_TWO_MASK))
    else $error("enable two write lost");
  en_two_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !e2_p.wr |=> $stable(e2_p.value)) else $error("enable two changed without write");
  flags_two_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    f2_p.wr && f2_p.set == 8'h00 |=> f2_p.value == ($past(pwdata[7:0]) & PIF_TWO_MASK))
    else $error("flag two write lost");
  rd_unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && is_at(paddr, PIF_FLAGS_ONE_OFF) |-> prdata[7] == 1'b0 && prdata[5:4] == 2'b00)
    else $error("unimplemented bit read as one");
  reset_clear_a: assert property (@(posedge pclk)
    $rose(presetn) |-> f1_p.value == 8'h00 && e1_p.value == 8'h00 && f2_p.value == 8'h00
                       && e2_p.value == 8'h00 && !periph_irq && !core_irq)
    else $error("register not cleared by reset");

  // ------------------------------------------------------------
  // Checks: requests to the core
  // ------------------------------------------------------------
  global_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !core_ctrl[PIF_BIT_GLOBAL] |=> !core_irq) else $error("core request without global enable");
  core_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !core_ctrl[PIF_BIT_GATE] |=> !core_irq) else $error("core request without gate");
  req_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !any_pending |=> !periph_irq) else $error("request without pending flag");
  core_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_pending && core_ctrl[PIF_BIT_GATE] && core_ctrl[PIF_BIT_GLOBAL] |=> core_irq)
    else $error("core request missing");

endmodule

// ### verif/pif_periph_model.sv
/*
  Stand-in for the peripherals around the flag block: turns a request
  vector from the bench into one-cycle event pulses on pclk.
  Assumes the bench holds each request for exactly one cycle.
*/
`timescale 1ns/1ns
module pif_periph_model
(
  // Clock and request
  input  wire logic       pclk,
  input  wire logic [9:0] fire,
  // Event pulses
  output logic            conv_done,
  output logic            serial_xfer_done,
  output logic            serial_seq_done,
  output logic            bus_cond_seen,
  output logic            capture_event,
  output logic            compare_match,
  output logic            period_match,
  output logic            wide_timer_ovf,
  output logic            bus_collision,
  output logic            low_voltage
);
  // Pulses only, so a missed edge in the block cannot be hidden
  always_ff @(posedge pclk)
    {low_voltage, bus_collision, wide_timer_ovf, period_match, compare_match, capture_event,
     bus_cond_seen, serial_seq_done, serial_xfer_done, conv_done} <= fire;
endmodule

// ### verif/testbench.sv
/*
  Self-checking bench for the flag block: APB master, queue of expected
  reads, event stimulus through the peripheral model.
  Assumes zero or more wait states from the slave.
*/
`timescale 1ns/1ns
module testbench;
  import pif_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h3e822eff;
  logic        pready, pslverr, periph_irq, core_irq, mmode = 0, sidle = 0;
  logic [1:0]  ccm = 2'b01;
  logic [9:0]  fire = 10'h0;
  logic [9:0]  ev;
  logic [32:0] q[$];
  int          n_errors = 0, checked = 0, cyc = 0;
  localparam logic [7:0] E1[10] = '{8'h40, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] E2[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h80};

  initial forever #50 pclk = ~pclk;

  pif_periph_model pm (.pclk(pclk), .fire(fire), .conv_done(ev[0]), .serial_xfer_done(ev[1]),
    .serial_seq_done(ev[2]), .bus_cond_seen(ev[3]), .capture_event(ev[4]), .compare_match(ev[5]),
    .period_match(ev[6]), .wide_timer_ovf(ev[7]), .bus_collision(ev[8]), .low_voltage(ev[9]));

  pif_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(ev[0]), .serial_xfer_done(ev[1]), .serial_master_mode(mmode), .serial_seq_done(ev[2]),
    .serial_idle(sidle), .bus_cond_seen(ev[3]), .capcmp_mode(ccm), .capture_event(ev[4]),
    .compare_match(ev[5]), .period_match(ev[6]), .wide_timer_ovf(ev[7]), .bus_collision(ev[8]),
    .low_voltage(ev[9]), .periph_irq(periph_irq), .core_irq(core_irq));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    // Callers pass word indices; the bus carries byte addresses
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {a[9:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic pulse(input logic [9:0] v);
    @(posedge pclk);
    fire <= v;
    @(posedge pclk);
    fire <= 10'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic complete_run;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read results taken at the accepting edge, oldest note first
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read", {pslverr, prdata}, q.pop_front());

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(PIF_FLAGS_ONE_OFF, 33'h0);
    rd(PIF_ENABLES_ONE_OFF, 33'h0);
    rd(12'h100, {1'b1, 32'h0});
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      xfer(1'b1, PIF_ENABLES_ONE_OFF, rnd);
      rd(PIF_ENABLES_ONE_OFF, {25'h0, rnd[7:0] & 8'h4f});
      xfer(1'b1, PIF_FLAGS_ONE_OFF, ~rnd);
      rd(PIF_FLAGS_ONE_OFF, {25'h0, ~rnd[7:0] & 8'h4f});
    end
    xfer(1'b1, PIF_ENABLES_TWO_OFF, 32'hff);
    rd(PIF_ENABLES_TWO_OFF, {25'h0, PIF_TWO_MASK});
    xfer(1'b1, PIF_ENABLES_ONE_OFF, 32'h0);
    xfer(1'b1, PIF_ENABLES_TWO_OFF, 32'h0);
    xfer(1'b1, PIF_FLAGS_ONE_OFF, 32'h0);
    $display("register test done");
    mmode <= 1'b1;
    sidle <= 1'b1;
    // Enables all clear, so every set below comes from the event alone
    for (int i = 0; i < 10; i++)
    begin
      ccm <= (i == 5) ? 2'b11 : 2'b01;
      pulse(10'h1 << i);
      repeat (5) @(posedge pclk);
      rd(PIF_FLAGS_ONE_OFF, {25'h0, E1[i]});
      rd(PIF_FLAGS_TWO_OFF, {25'h0, E2[i]});
      xfer(1'b1, PIF_FLAGS_ONE_OFF, 32'h0);
      xfer(1'b1, PIF_FLAGS_TWO_OFF, 32'h0);
    end
    ccm <= 2'b10;
    pulse(10'h030);
    rd(PIF_FLAGS_ONE_OFF, 33'h0);
    $display("event test done");
    xfer(1'b1, PIF_FLAGS_ONE_OFF, 32'h0);
    xfer(1'b1, PIF_ENABLES_ONE_OFF, 32'h4f);
    xfer(1'b1, PIF_CORE_CTRL_OFF, 32'h0);
    pulse(10'h001);
    check("periph_irq", {32'h0, periph_irq}, 33'h0);
    xfer(1'b1, PIF_CORE_CTRL_OFF, 32'h40);
    repeat (2) @(posedge pclk);
    check("periph_irq", {32'h0, periph_irq}, 33'h1);
    check("core_irq", {32'h0, core_irq}, 33'h0);
    xfer(1'b1, PIF_CORE_CTRL_OFF, 32'hc0);
    repeat (2) @(posedge pclk);
    check("core_irq", {32'h0, core_irq}, 33'h1);
    xfer(1'b1, PIF_FLAGS_ONE_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    check("periph_irq", {32'h0, periph_irq}, 33'h0);
    xfer(1'b1, PIF_FLAGS_ONE_OFF, 32'h01);
    repeat (2) @(posedge pclk);
    check("periph_irq", {32'h0, periph_irq}, 33'h1);
    $display("request test done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check("periph_irq", {32'h0, periph_irq}, 33'h0);
    rd(PIF_FLAGS_ONE_OFF, 33'h0);
    rd(PIF_ENABLES_ONE_OFF, 33'h0);
    $display("second reset test done");
    complete_run;
  end
endmodule
